/* rtl/typec_irq_defs.svh */
// Register map, field positions, reset values for the status/interrupt block
// Included by the status/interrupt register module only; definitions only
`ifndef TYPEC_IRQ_DEFS_SVH
`define TYPEC_IRQ_DEFS_SVH
`define ADDR_CONTROL        8'h04
`define ADDR_MASK_PRI       8'h0E
`define ADDR_MASK_SEC       8'h0F
`define ADDR_COND           8'h11
`define ADDR_COND_EXT       8'h12
`define ADDR_KIND           8'h13
`define ADDR_FLAGS          8'h14
`define ADDR_FLAGS_SEC      8'h15
`define RST_CONTROL         8'h4B
`define RST_ZERO            8'h00
`define MASK_PRI_USED       8'h7F
`define MASK_SEC_USED       8'h6F
`define KIND_USED           8'h7F
`define COND_EXT_USED       8'h03
`define CTRL_GLOBAL_MASK    0
`define EV_CC_SIDE          6
`define EV_FAULT            5
`define EV_BUS_POWER        4
`define EV_WEAK_BATT        3
`define EV_CUR_LEVEL        2
`define EV_DETACH           1
`define EV_ATTACH           0
`define CC_SIDE_NONE        2'h0
`define CC_SIDE_FAULT       2'h3
`endif

/* rtl/typec_irq_pkg.sv */
// Types shared by the status/interrupt block
// Assumes the defs header is on the include path
package typec_irq_pkg;
  typedef logic [7:0] reg_byte_t;  // One register byte
  typedef enum logic [2:0] {
    PIN_IDLE   = 3'h1,
    PIN_ASSERT = 3'h2,
    PIN_HOLD   = 3'h4
  } pin_state_t;
endpackage : typec_irq_pkg

/* rtl/w1c_flag_bank.sv */
// Bank of write-one-to-clear sticky event flags
// Assumes set and clear strobes come from the same clock domain
`timescale 1ns/1ps
module w1c_flag_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,    // System clock
  input  wire logic             rst_in,    // Sync reset, active high
  input  wire logic [WIDTH-1:0] set_in,    // Event pulses
  input  wire logic [WIDTH-1:0] clr_in,    // Write-one clear strobes
  output logic      [WIDTH-1:0] flags_out  // Sticky flags
);
  ////////////////////////////////////////////////////////////////////////////
  // One flag per bit; set beats clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          flags_out[g] <= 1'b0;  // RULE13
        end else if (set_in[g]) begin
          flags_out[g] <= 1'b1;  // Set wins
        end else if (clr_in[g]) begin
          flags_out[g] <= 1'b0;  // RULE13
        end
      end
    end
  endgenerate
endmodule : w1c_flag_bank

/* rtl/typec_status_interrupt_regs.sv */
// Status, attach-kind, event flag and mask registers of a Type-C port controller
// Assumes condition inputs come from same-clock detection logic; register port
// is a simple byte read/write strobe interface from the I2C target logic.
// Limitation: events are seen once per clock, so a level that flips and
// returns inside one cycle raises no flag.
// What this block does
// RULE1 - Primary mask gates seven event flags
// RULE2 - Secondary mask gates six remedy/force flags
// RULE3 - Masked events still set their flag
// RULE4 - Condition bit 7 shows weak-battery sink
// RULE5 - Condition bit 6 shows near-zero bus power
// RULE6 - Two-bit field reports CC side
// RULE7 - Condition bit 3 shows valid bus power
// RULE8 - Two-bit field reports advertised current
// RULE9 - Condition bit 0 shows attached
// RULE10 - Extended bit 1 shows sink CC fault
// RULE11 - Extended bit 0 shows remedy active
// RULE12 - Kind register flags attached role
// RULE13 - Flags reset zero, write one clears
// RULE14 - CC side flag on 00 to 01/10
// RULE15 - Fault flag on CC over Rd range
// RULE16 - Bus power flag on threshold crossing
// RULE17 - Weak-battery flag on enter and leave
// RULE18 - Current flag on level change
// RULE19 - Detach flag on detach
// RULE20 - Attach flag on attach
// RULE21 - Global mask blocks the request pin
// RULE22 - Second flag register holds remedy events
// RULE23 - Pin low on any unmasked flag
// RULE24 - Reserved bits read zero
`timescale 1ns/1ps
`include "typec_irq_defs.svh"
module typec_status_interrupt_regs
  import typec_irq_pkg::*;
(
  input  wire logic       clk_in,                  // System clock, 100 MHz
  input  wire logic       rst_in,                  // Sync reset, active high
  input  wire logic [7:0] reg_addr_in,             // Register address
  input  wire logic       reg_wr_in,               // Write strobe, one cycle
  input  wire logic [7:0] reg_wdata_in,            // Write data
  input  wire logic       reg_rd_in,               // Read strobe, one cycle
  output logic      [7:0] reg_rdata_out,           // Read data, next cycle
  output logic            reg_rvalid_out,          // Read data valid pulse
  input  wire logic       weak_batt_sink_active_in,// Weak-battery sink mode on
  input  wire logic       bus_power_near_zero_in,  // VBUS sense below safe zero
  input  wire logic [1:0] cc_side_in,              // Orientation code
  input  wire logic       bus_power_valid_in,      // VBUS sense in 5 V range
  input  wire logic [1:0] advertised_current_level_in, // CC current level
  input  wire logic       attached_in,             // Port attached
  input  wire logic       cc_fault_in,             // Sink CC over Rd range
  input  wire logic       rd_applied_in,           // Rd termination applied
  input  wire logic       remedy_active_in,        // Remedy methods running
  input  wire logic [6:0] attached_kind_in,        // Attached role flags
  input  wire logic [7:0] remedy_event_in,         // Remedy/force event pulses
  output logic            irq_n_out,               // Interrupt request, low
  output logic            irq_n_oe_n_out           // Pin enable, low drives
);
  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  reg_byte_t control_r;           // Control, bit 0 global mask
  reg_byte_t irq_mask_primary_r;  // Primary mask
  reg_byte_t irq_mask_secondary_r;// Secondary mask

  // Writes to read-only and unmapped addresses decode to nothing,
  // so they cannot disturb the status bytes
  // Write enables by address
  logic wr_ctrl, wr_mpri, wr_msec, wr_fl, wr_fl2;
  assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_CONTROL);
  assign wr_mpri = reg_wr_in && (reg_addr_in == `ADDR_MASK_PRI);
  assign wr_msec = reg_wr_in && (reg_addr_in == `ADDR_MASK_SEC);
  assign wr_fl   = reg_wr_in && (reg_addr_in == `ADDR_FLAGS);
  assign wr_fl2  = reg_wr_in && (reg_addr_in == `ADDR_FLAGS_SEC);

  // Only the global mask bit is used here; the other fields are kept
  // for the detection logic and read back as written
  // Control register storage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      control_r <= `RST_CONTROL;
    end else if (wr_ctrl) begin
      control_r <= reg_wdata_in;
    end
  end

  // Reserved mask bits are dropped on the way in, so they read back zero
  // and leave unmasked only flag positions that never set
  // Mask registers, reserved bits forced zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_mask_primary_r   <= `RST_ZERO;
      irq_mask_secondary_r <= `RST_ZERO;
    end else begin
      if (wr_mpri) begin
        irq_mask_primary_r <= reg_wdata_in & `MASK_PRI_USED;  // RULE1 RULE24
      end
      if (wr_msec) begin
        irq_mask_secondary_r <= reg_wdata_in & `MASK_SEC_USED;  // RULE2 RULE24
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The condition copy feeds both the read path and the edge detectors,
  // so a flag and the status bit that caused it appear on the same edge.
  // The fault copy remembers the qualified fault so it flags only once.
  // Condition snapshots for edge detection
  reg_byte_t port_condition_r;     // Condition register
  reg_byte_t port_condition_ext_r; // Extended condition
  reg_byte_t attached_kind_r;      // Attached kind
  reg_byte_t port_condition_nxt;   // Next condition value
  logic      fault_seen_r;         // Previous qualified fault

  // Assemble live condition byte
  always_comb begin
    port_condition_nxt      = `RST_ZERO;
    port_condition_nxt[7]   = weak_batt_sink_active_in;     // RULE4
    port_condition_nxt[6]   = bus_power_near_zero_in;       // RULE5
    port_condition_nxt[5:4] = cc_side_in;                   // RULE6
    port_condition_nxt[3]   = bus_power_valid_in;           // RULE7
    port_condition_nxt[2:1] = advertised_current_level_in;  // RULE8
    port_condition_nxt[0]   = attached_in;                  // RULE9
  end

  // Register the live condition
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port_condition_r     <= `RST_ZERO;
      port_condition_ext_r <= `RST_ZERO;
      attached_kind_r      <= `RST_ZERO;
      fault_seen_r         <= 1'b0;
    end else begin
      port_condition_r     <= port_condition_nxt;
      port_condition_ext_r <= {6'h00, cc_fault_in, remedy_active_in};  // RULE10 RULE11
      attached_kind_r      <= {1'b0, attached_kind_in};  // RULE12
      fault_seen_r         <= cc_fault_in && rd_applied_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each event compares a registered copy with the live input, so one
  // change gives exactly one set pulse.
  // CC side: only a move out of 00 into a resolved side counts; a move to
  // the fault code 11 and a return to 00 stay silent.
  // Bus power: either threshold bit moving, in either direction, counts.
  // Event detection from condition changes
  logic [7:0] event_set;  // Primary flag set pulses
  always_comb begin
    event_set = 8'h00;
    event_set[`EV_CC_SIDE] = (port_condition_r[5:4] == `CC_SIDE_NONE)
                          && (cc_side_in != `CC_SIDE_NONE)
                          && (cc_side_in != `CC_SIDE_FAULT);  // RULE14
    event_set[`EV_FAULT] = cc_fault_in && rd_applied_in && !fault_seen_r;  // RULE15
    event_set[`EV_BUS_POWER] = (port_condition_r[6] != bus_power_near_zero_in)
                            || (port_condition_r[3] != bus_power_valid_in);  // RULE16
    event_set[`EV_WEAK_BATT] = port_condition_r[7] != weak_batt_sink_active_in;  // RULE17
    event_set[`EV_CUR_LEVEL] = port_condition_r[2:1] != advertised_current_level_in;  // RULE18
    event_set[`EV_DETACH] = port_condition_r[0] && !attached_in;  // RULE19
    event_set[`EV_ATTACH] = !port_condition_r[0] && attached_in;  // RULE20
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set beats a clear in the same cycle, so an event that arrives during
  // the host's clear write is not lost; the host sees it on its next read.
  // Reserved positions are never set.
  // Sticky flag banks; masks do not gate the setting
  logic [7:0] event_flags;      // Primary flags
  logic [7:0] event_flags_sec;  // Secondary flags

  w1c_flag_bank #(.WIDTH(8)) u_flags_pri (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .set_in    (event_set & `MASK_PRI_USED),                       // RULE3
    .clr_in    (wr_fl ? reg_wdata_in : 8'h00),                     // RULE13
    .flags_out (event_flags)
  );

  w1c_flag_bank #(.WIDTH(8)) u_flags_sec (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .set_in    (remedy_event_in & `MASK_SEC_USED),                 // RULE22
    .clr_in    (wr_fl2 ? reg_wdata_in : 8'h00),                    // RULE22
    .flags_out (event_flags_sec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The pin is open drain: data is held low and the enable does the work.
  // Driving it from a register costs one cycle after the flag, but keeps
  // glitches of the mask and flag decode off the pin.
  // Masks act only here, never on the flags themselves.
  // Interrupt pin: one-hot state tracks the drive
  logic       irq_pending;  // Any unmasked flag
  pin_state_t pin_state_r;  // Pin state
  assign irq_pending = !control_r[`CTRL_GLOBAL_MASK]
                    && (|(event_flags & ~irq_mask_primary_r)
                     || |(event_flags_sec & ~irq_mask_secondary_r));  // RULE21 RULE23

  // The state tracks how long the request has stood; it agrees with the
  // pin enable every cycle and is checked against it below.
  // Pin state machine
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_state_r <= PIN_IDLE;
    end else begin
      case (pin_state_r)
        PIN_IDLE:   pin_state_r <= irq_pending ? PIN_ASSERT : PIN_IDLE;
        PIN_ASSERT: pin_state_r <= irq_pending ? PIN_HOLD : PIN_IDLE;
        PIN_HOLD:   pin_state_r <= irq_pending ? PIN_HOLD : PIN_IDLE;
        default:    pin_state_r <= PIN_IDLE;
      endcase
    end
  end

  // Registered pin drive, open drain: drive low only
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_n_out      <= 1'b1;
      irq_n_oe_n_out <= 1'b1;
    end else begin
      irq_n_out      <= 1'b0;
      irq_n_oe_n_out <= !irq_pending;  // RULE23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads are registered, so a condition byte is one cycle older than the
  // inputs; unmapped addresses read as zero, never as unknown.
  // Read data holds until the next read strobe.
  // Read path, one cycle latency
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out  <= `RST_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `ADDR_CONTROL:   reg_rdata_out <= control_r;
          `ADDR_MASK_PRI:  reg_rdata_out <= irq_mask_primary_r;
          `ADDR_MASK_SEC:  reg_rdata_out <= irq_mask_secondary_r;
          `ADDR_COND:      reg_rdata_out <= port_condition_r;
          `ADDR_COND_EXT:  reg_rdata_out <= port_condition_ext_r & `COND_EXT_USED;  // RULE24
          `ADDR_KIND:      reg_rdata_out <= attached_kind_r & `KIND_USED;  // RULE24
          `ADDR_FLAGS:     reg_rdata_out <= event_flags;
          `ADDR_FLAGS_SEC: reg_rdata_out <= event_flags_sec;
          default:         reg_rdata_out <= `RST_ZERO;  // Unmapped reads zero
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Condition flag checks compare values sampled at the same edge: the condition
  // copy and the flag bank update together, so a change seen in the copy
  // must already show in its flag. Set beats clear, so a clear write in
  // the same cycle cannot hide a new flag.
  AST_PIN_FOLLOWS: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE23
    irq_pending |=> !irq_n_oe_n_out) else $error("pin not driven on pending flag");
  AST_GLOBAL_MASK: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE21
    control_r[0] |=> irq_n_oe_n_out) else $error("pin driven under global mask");
  AST_MASK_PRI: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE1
    (event_flags_sec == 8'h00 && (event_flags & ~irq_mask_primary_r) == 8'h00)
    |=> irq_n_oe_n_out) else $error("masked flag drove pin");
  AST_MASK_SEC: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE2
    (event_flags == 8'h00 && (event_flags_sec & ~irq_mask_secondary_r) == 8'h00)
    |=> irq_n_oe_n_out) else $error("masked secondary flag drove pin");
  AST_MASKED_SETS: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE3
    event_set[`EV_ATTACH] |=> event_flags[`EV_ATTACH]) else $error("attach flag lost");
  AST_W1C: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE13
    (wr_fl && reg_wdata_in[1] && !event_set[1]) |=> !event_flags[1])
    else $error("write one did not clear");
  AST_CC_SIDE: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE14
    ($past(port_condition_r[5:4]) == 2'h0 && port_condition_r[5:4] == 2'h3
     && !$past(event_flags[6])) |-> !event_flags[6]) else $error("cc side flag on fault");
  AST_DETACH: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE19
    $fell(port_condition_r[0]) |-> event_flags[1]) else $error("detach flag missing");
  AST_WEAK: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE17
    $changed(port_condition_r[7]) |-> event_flags[3]) else $error("weak batt flag missing");
  AST_RSVD: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE24
    !irq_mask_primary_r[7] && irq_mask_secondary_r[4] == 1'b0) else $error("reserved set");

  // Pin state machine and registered drive agree every cycle
  AST_PIN_STATE: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE23
    (pin_state_r == PIN_IDLE) == irq_n_oe_n_out)
    else $error("pin state and pin drive disagree");

  // Open-drain data stays low out of reset; only the enable moves
  AST_PIN_LEVEL: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE23
    1'b1 |=> !irq_n_out) else $error("pin data left low level");

  // Read data valid follows every read strobe by one cycle
  AST_RVALID: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE13
    reg_rd_in |=> reg_rvalid_out) else $error("read valid missing");

  // Condition read returns the byte held at the strobe
  AST_RD_COND: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE9
    (reg_rd_in && reg_addr_in == `ADDR_COND) |=> reg_rdata_out == $past(port_condition_r))
    else $error("condition read mismatch");

  // Flag read returns the flags held at the strobe
  AST_RD_FLAGS: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE13
    (reg_rd_in && reg_addr_in == `ADDR_FLAGS) |=> reg_rdata_out == $past(event_flags))
    else $error("flag read mismatch");

  // Attach seen in the condition copy implies its flag
  AST_ATTACH: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE20
    $rose(port_condition_r[0]) |-> event_flags[`EV_ATTACH])
    else $error("attach flag missing");

  // Any change of the current field implies its flag
  AST_CUR_LEVEL: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE18
    $changed(port_condition_r[2:1]) |-> event_flags[`EV_CUR_LEVEL])
    else $error("current level flag missing");

  // Either bus power bit moving implies its flag
  AST_BUS_POWER: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE16
    ($changed(port_condition_r[6]) || $changed(port_condition_r[3]))
    |-> event_flags[`EV_BUS_POWER]) else $error("bus power flag missing");

  // A new qualified fault implies the fault flag
  AST_FAULT: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE15
    $rose(fault_seen_r) |-> event_flags[`EV_FAULT]) else $error("fault flag missing");

  // Reserved flag positions never set
  AST_FLAG_RSVD: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE24
    !event_flags[7] && !event_flags_sec[7] && !event_flags_sec[4])
    else $error("reserved flag set");

  // Reserved status and kind bits stay zero
  AST_STATUS_RSVD: assert property (@(posedge clk_in) disable iff (rst_in)  // RULE24
    port_condition_ext_r[7:2] == 6'h00 && !attached_kind_r[7])
    else $error("reserved status bit set");

  // Cover points for the main scenarios
  COV_ATTACH: cover property (@(posedge clk_in) disable iff (rst_in)
    event_set[0] ##1 !irq_n_oe_n_out);
  COV_CLEAR: cover property (@(posedge clk_in) disable iff (rst_in)
    !irq_n_oe_n_out ##1 wr_fl ##2 irq_n_oe_n_out);
  COV_SEC: cover property (@(posedge clk_in) disable iff (rst_in) |event_flags_sec);
  COV_MASKED: cover property (@(posedge clk_in) disable iff (rst_in)
    |(event_flags & irq_mask_primary_r) && irq_n_oe_n_out);
  COV_GLOBAL: cover property (@(posedge clk_in) disable iff (rst_in)
    control_r[`CTRL_GLOBAL_MASK] && |event_flags_sec);
endmodule : typec_status_interrupt_regs

/* tb/cc_detect_model.sv */
// Detection-side model: drives attach, CC side, current level, role
// Assumes bench requests made on the falling edge, one cycle ahead
`timescale 1ns/1ps
module cc_detect_model (
  input  wire logic       clk_in,        // System clock
  input  wire logic       attach_req_in, // Attach wanted
  input  wire logic [1:0] side_req_in,   // CC side wanted
  input  wire logic [1:0] lvl_req_in,    // Current level wanted
  input  wire logic [6:0] kind_req_in,   // Role wanted
  output logic            attached_out,  // Attached level
  output logic      [1:0] cc_side_out,   // CC side level
  output logic      [1:0] level_out,     // Current level
  output logic      [6:0] kind_out       // Role flags
);
  // Levels move off the sampling edge; role shown only while attached
  always @(negedge clk_in) begin
    attached_out <= attach_req_in;
    cc_side_out  <= side_req_in;
    level_out    <= lvl_req_in;
    kind_out     <= attach_req_in ? kind_req_in : 7'h00;
  end
endmodule : cc_detect_model

/* tb/tb_typec_status_interrupt_regs.sv */
// Self-checking bench for the status and event flag register block
// Assumes the detection model beside it and a strobe register port
`timescale 1ns/1ps
module tb_typec_status_interrupt_regs
  import typec_irq_pkg::*;
;
  logic      clk_in = 1'b0, rst_in = 1'b1;             // Clock, reset
  reg_byte_t addr = 8'h00, wdata = 8'h00, remev = 8'h00; // Bus, pulses
  logic      wr = 1'b0, rd = 1'b0, rvalid, irq_n, oe_n;  // Strobes, pin
  reg_byte_t rdata, cur = 8'h00;                         // Read data, last state
  logic      wb = 0, nz = 0, pv = 0, flt = 0, rda = 0, rem = 0; // Levels
  logic      att_q = 0, att;                             // Attach request, level
  logic [1:0] side_q = 0, lvl_q = 0, side, lvl;          // Requests, levels
  logic [6:0] kind_q = 0, kind;                          // Role request, level
  logic [31:0] lfsr = 32'h8FA7;                          // Random state
  int        n_fail = 0, total_checks = 0, cyc = 0;      // Counters
  reg_byte_t exp_rst [9] = '{8'h4B, 0, 0, 0, 0, 0, 0, 0, 0}; // Reset values
  reg_byte_t adr_rst [9] = '{8'h04, 8'h0E, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h30};

  // Clock, 10 ns period
  initial forever #5 clk_in = ~clk_in;

  cc_detect_model u_cc_detect_model (.clk_in(clk_in), .attach_req_in(att_q),
    .side_req_in(side_q), .lvl_req_in(lvl_q), .kind_req_in(kind_q),
    .attached_out(att), .cc_side_out(side), .level_out(lvl), .kind_out(kind));

  typec_status_interrupt_regs u_typec_status_interrupt_regs (.clk_in(clk_in),
    .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .weak_batt_sink_active_in(wb), .bus_power_near_zero_in(nz), .cc_side_in(side),
    .bus_power_valid_in(pv), .advertised_current_level_in(lvl), .attached_in(att),
    .cc_fault_in(flt), .rd_applied_in(rda), .remedy_active_in(rem),
    .attached_kind_in(kind), .remedy_event_in(remev), .irq_n_out(irq_n),
    .irq_n_oe_n_out(oe_n));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string name, input reg_byte_t seen, input reg_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One write strobe
  task automatic wr_reg(input reg_byte_t a, input reg_byte_t d);
    @(negedge clk_in);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(negedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // One read strobe, data taken in the valid cycle
  task automatic rchk(input reg_byte_t a, input reg_byte_t exp);
    @(negedge clk_in);
    {addr, rd} <= {a, 1'b1};
    @(negedge clk_in);
    rd <= 1'b0;
    chk("read valid", {7'h00, rvalid}, 8'h01);
    chk($sformatf("register %h", a), rdata, exp);
  endtask : rchk

  // Pin level after settling
  task automatic pin(input logic exp_n);
    repeat (4) @(negedge clk_in);
    chk("pin enable", {7'h00, oe_n}, {7'h00, exp_n});
  endtask : pin

  // Expected event flags from old and new condition bytes
  function automatic reg_byte_t ev(input reg_byte_t p, input reg_byte_t n);
    ev    = 8'h00;
    ev[6] = p[5:4] == 2'h0 && (n[5:4] == 2'h1 || n[5:4] == 2'h2);
    ev[4] = p[6] != n[6] || p[3] != n[3];
    ev[3] = p[7] != n[7];
    ev[2] = p[2:1] != n[2:1];
    ev[1] = p[0] & ~n[0];
    ev[0] = ~p[0] & n[0];
  endfunction : ev

  // Apply a condition byte, check pin, status, role, flags, then clear
  task automatic step(input reg_byte_t n, input logic [6:0] k);
    reg_byte_t f;
    f = ev(cur, n);
    @(negedge clk_in);
    {wb, nz, side_q, pv, lvl_q, att_q} <= n;
    kind_q <= k;
    pin(f == 8'h00);
    rchk(8'h11, n);
    rchk(8'h13, n[0] ? {1'b0, k} : 8'h00);
    rchk(8'h14, f);
    wr_reg(8'h14, f);
    rchk(8'h14, 8'h00);
    cur = n;
  endtask : step

  // Next random word from the feedback register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(negedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 9; i++) rchk(adr_rst[i], exp_rst[i]);
    chk("pin after reset", {7'h00, oe_n}, 8'h01);
    wr_reg(8'h04, 8'h4A);
    wr_reg(8'h11, 8'hFF);
    $display("test reset done");
    step(8'h13, 7'h08);
    step(8'h4B, 7'h08);
    step(8'h48, 7'h00);
    step(8'h30, 7'h00);
    step(8'h00, 7'h00);
    step(8'hA5, 7'h41);
    chk("request level", {7'h00, irq_n}, 8'h00);
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsr_next(lfsr);
      step(lfsr[7:0], lfsr[14:8]);
    end
    $display("test conditions done");
    @(negedge clk_in);
    {flt, rda, rem} <= 3'b111;
    pin(1'b0);
    rchk(8'h12, 8'h03);
    wr_reg(8'h14, 8'h00);
    rchk(8'h14, 8'h20);
    wr_reg(8'h14, 8'h20);
    wr_reg(8'h0E, 8'hFF);
    rchk(8'h0E, 8'h7F);
    @(negedge clk_in);
    flt <= 1'b0;
    @(negedge clk_in);
    flt <= 1'b1;
    pin(1'b1);
    rchk(8'h14, 8'h20);
    $display("test fault and primary mask done");
    wr_reg(8'h0F, 8'hFF);
    rchk(8'h0F, 8'h6F);
    @(negedge clk_in);
    remev <= 8'hFF;
    @(negedge clk_in);
    remev <= 8'h00;
    pin(1'b1);
    rchk(8'h15, 8'h6F);
    wr_reg(8'h0F, 8'h00);
    pin(1'b0);
    wr_reg(8'h04, 8'h4B);
    pin(1'b1);
    rchk(8'h04, 8'h4B);
    wr_reg(8'h04, 8'h4A);
    pin(1'b0);
    wr_reg(8'h15, 8'h6F);
    rchk(8'h15, 8'h00);
    wr_reg(8'h14, 8'hFF);
    pin(1'b1);
    $display("test secondary and global mask done");
    print_verdict();
  end
endmodule : tb_typec_status_interrupt_regs
